// *** include/adc_seq_pkg.sv ***
// constants, register map and route codes for the converter sequencer
package adc_seq_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int TAD_MIN_PS = 117600;
  localparam int TAD_CYCLES = (TAD_MIN_PS + CLK_PERIOD_NS * 1000 - 1) / (CLK_PERIOD_NS * 1000);
  localparam int RESTART_CYCLES = (TAD_CYCLES + 1) / 2;
  localparam logic [3:0] RESTART_LAST = 4'(RESTART_CYCLES - 1);
  localparam int SETTLE_US = 20;
  localparam int SETTLE_CYCLES = SETTLE_US * 1000 / CLK_PERIOD_NS;
  localparam logic [8:0] SETTLE_LAST = 9'(SETTLE_CYCLES - 1);
  localparam logic [4:0] CONV_TADS = 5'h0E;
  localparam logic [4:0] START_TADS = 5'h02;
  localparam logic [4:0] DMA_LAST = 5'h1F;
  localparam int NUM_BUFFERS = 16;
  localparam int RESULT_W = 12;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL1 = 8'h00;
  localparam logic [7:0] OFS_CTRL2 = 8'h04;
  localparam logic [7:0] OFS_CHS0 = 8'h08;
  localparam logic [7:0] OFS_SCAN_LO = 8'h0C;
  localparam logic [7:0] OFS_SCAN_HI = 8'h10;
  localparam logic [7:0] OFS_SAMPLE_CONTROL_BIT_TIME = 8'h14;
  localparam logic [7:0] OFS_AMP_MODE = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
  localparam logic [7:0] OFS_BUF = 8'h40;
  // field positions
  localparam int CTRL1_ON_BIT = 15;
  localparam int CTRL1_READY_BIT = 14;
  localparam int CTRL1_AUTO_CONV_BIT = 5;
  localparam int CTRL1_AUTO_SAMPLE_RESTART_BIT = 2;
  localparam int CTRL1_SAMPLE_CONTROL_BIT_BIT = 1;
  localparam int CTRL1_DONE_BIT = 0;
  localparam int CTRL2_DMA_BIT = 11;
  localparam int CTRL2_SCAN_BIT = 10;
  localparam int CTRL2_SMPI_LSB = 2;
  localparam int CTRL2_ALT_BIT = 0;
  localparam int CHS0_NB_BIT = 15;
  localparam int CHS0_SB_LSB = 8;
  localparam int CHS0_NA_BIT = 7;
  localparam int CHS0_SA_LSB = 0;
  localparam logic [15:0] CHS0_MASK = 16'h9F9F;
  localparam int IRQ_COUNT_BIT = 0;
  localparam int IRQ_DONE_BIT = 1;
  localparam int IRQ_OVERRUN_BIT = 2;
  localparam int IRQ_W = 3;
  // reset values
  localparam logic [15:0] CHS0_RST = 16'h0000;
  localparam logic [31:0] SCAN_RST = 32'h0000_0000;
  localparam logic [4:0] SMPI_RST = 5'h00;
  localparam logic [4:0] SAMPLE_CONTROL_BIT_TIME_RST = 5'h03;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;
  // positive select codes
  localparam logic [4:0] SEL_AN_LAST = 5'h0F;
  localparam logic [4:0] SEL_AMP1 = 5'h18;
  localparam logic [4:0] SEL_AMP3 = 5'h1A;
  localparam logic [4:0] SEL_TEMP = 5'h1E;
  localparam logic [4:0] SEL_OPEN = 5'h1F;
  // analog route codes: 0..15 are analog input pins
  localparam logic [5:0] ROUTE_AMP1 = 6'h10;
  localparam logic [5:0] ROUTE_TEMP = 6'h13;
  localparam logic [5:0] ROUTE_OPEN = 6'h14;
  localparam logic [5:0] ROUTE_RSVD = 6'h15;
  localparam logic [5:0] ROUTE_LOW_VOLTAGE_REFERENCE = 6'h16;
  localparam logic [5:0] ROUTE_AN1 = 6'h01;
  localparam logic [5:0] AMP_PIN [3] = '{6'h03, 6'h00, 6'h06};
endpackage

// *** hdl/tad_timer.sv ***
// converter clock period tick generator, restartable at phase boundaries
`timescale 1ns/1ps
`default_nettype none
module tad_timer #(
  parameter int DIV = adc_seq_pkg::TAD_CYCLES
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic restart_i,
  output logic tick_o
);
  logic [7:0] cnt_q;

  // restart aligns the period to the phase start so delays are exact
  always_ff @(posedge clk_i) begin
    if (rst_i || restart_i || cnt_q == 8'(DIV - 1)) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  assign tick_o = !restart_i && cnt_q == 8'(DIV - 1);
endmodule
`default_nettype wire

// *** hdl/input_router.sv ***
// decodes channel 0 selects into analog route codes
`timescale 1ns/1ps
`default_nettype none
module input_router (
  input wire logic [4:0] pos_sel_i,
  input wire logic neg_sel_i,
  input wire logic [2:0] amp_mode_i,
  output logic [5:0] pos_route_o,
  output logic [5:0] neg_route_o
);
  import adc_seq_pkg::*;
  logic [1:0] amp_idx;

  assign amp_idx = 2'(pos_sel_i - SEL_AMP1);
  assign neg_route_o = neg_sel_i ? ROUTE_AN1 : ROUTE_LOW_VOLTAGE_REFERENCE;

  always_comb begin
    if (pos_sel_i <= SEL_AN_LAST) begin
      pos_route_o = {1'b0, pos_sel_i};
    end else if (pos_sel_i >= SEL_AMP1 && pos_sel_i <= SEL_AMP3) begin
      pos_route_o = amp_mode_i[amp_idx] ? ROUTE_AMP1 + 6'(amp_idx) : AMP_PIN[amp_idx];
    end else if (pos_sel_i == SEL_TEMP) begin
      pos_route_o = ROUTE_TEMP;
    end else if (pos_sel_i == SEL_OPEN) begin
      pos_route_o = ROUTE_OPEN;
    end else begin
      pos_route_o = ROUTE_RSVD;
    end
  end
endmodule
`default_nettype wire

// *** hdl/adc_sequencer.sv ***
// converter sequencer: phase timing, result buffer, scan, dma pacing and wishbone registers
`timescale 1ns/1ps
`default_nettype none
module adc_sequencer #(
  parameter int NBUF = adc_seq_pkg::NUM_BUFFERS,
  parameter int RES_W = adc_seq_pkg::RESULT_W
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [RES_W-1:0] conv_result_i,
  output logic sample_o,
  output logic converting_o,
  output logic [5:0] pos_route_o,
  output logic [5:0] neg_route_o,
  output logic dma_addr_inc_o,
  output logic irq_o
);
  import adc_seq_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_SAMPLE_CONTROL_BIT_WAIT, S_SAMPLE, S_CONV_WAIT, S_CONVERT, S_RESTART} phase_e;

  localparam int PTR_W = $clog2(NBUF);

  phase_e state_q, state_d;
  logic on_q, ready_q, auto_conv_q, auto_sample_restart_q, sample_control_bit_q, done_q;
  logic dma_en_q, scan_en_q, alt_q, use_b_q, unread_q;
  logic [4:0] smpi_q, sample_control_bit_time_q, conv_cnt_q, scan_idx_q, dma_cnt_q, tad_cnt_q;
  logic [15:0] chs0_q;
  logic [31:0] scan_sel_q;
  logic [2:0] amp_mode_q, irq_stat_q, irq_mask_q, irq_set;
  logic [RES_W-1:0] buf_q [NBUF];
  logic [PTR_W-1:0] ptr_q;
  logic [3:0] half_cnt_q;
  logic [8:0] settle_cnt_q;
  logic bus_req, acc_wr, acc_rd, tick, phase_change, conv_start, conv_done, last;
  logic [15:0] wmask;
  logic [4:0] pos_sel, first_idx;
  logic neg_sel;
  logic [5:0] pos_route, neg_route;
  logic [31:0] rdata;

  function automatic logic [4:0] next_set(input logic [31:0] m, input logic [4:0] cur);
    logic [4:0] r;
    logic [4:0] k;
    logic found;
    r = cur;
    found = 1'b0;
    for (int i = 1; i <= 32; i++) begin
      k = cur + 5'(i);
      if (!found && m[k]) begin
        r = k;
        found = 1'b1;
      end
    end
    return r;
  endfunction

  // ---------------- bus slave ----------------
  // ack one cycle after the request; writes and read side effects land on the ack edge
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign acc_wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;
  assign acc_rd = wb_cyc_i && wb_stb_i && wb_ack_o && !wb_we_i;
  assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [15:0] m);
    return (old & ~m) | (nw & m);
  endfunction

  always_comb begin
    rdata = 32'h0000_0000;
    if (wb_adr_i[7:6] == OFS_BUF[7:6]) begin
      if (32'(wb_adr_i[5:2]) < NBUF) begin
        rdata[RES_W-1:0] = buf_q[wb_adr_i[5:2]];
      end
    end else begin
      unique case ({wb_adr_i[7:2], 2'b00})
        OFS_CTRL1: begin
          rdata[CTRL1_ON_BIT] = on_q;
          rdata[CTRL1_READY_BIT] = ready_q;
          rdata[CTRL1_AUTO_CONV_BIT] = auto_conv_q;
          rdata[CTRL1_AUTO_SAMPLE_RESTART_BIT] = auto_sample_restart_q;
          rdata[CTRL1_SAMPLE_CONTROL_BIT_BIT] = sample_control_bit_q;
          rdata[CTRL1_DONE_BIT] = done_q;
        end
        OFS_CTRL2: begin
          rdata[CTRL2_DMA_BIT] = dma_en_q;
          rdata[CTRL2_SCAN_BIT] = scan_en_q;
          rdata[CTRL2_SMPI_LSB +: 5] = smpi_q;
          rdata[CTRL2_ALT_BIT] = alt_q;
        end
        OFS_CHS0: rdata[15:0] = chs0_q;
        OFS_SCAN_LO: rdata[15:0] = scan_sel_q[15:0];
        OFS_SCAN_HI: rdata[15:0] = scan_sel_q[31:16];
        OFS_SAMPLE_CONTROL_BIT_TIME: rdata[4:0] = sample_control_bit_time_q;
        OFS_AMP_MODE: rdata[2:0] = amp_mode_q;
        OFS_IRQ_STAT: rdata[IRQ_W-1:0] = irq_stat_q;
        OFS_IRQ_MASK: rdata[IRQ_W-1:0] = irq_mask_q;
        default: rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req) begin
        wb_dat_o <= rdata;
      end
    end
  end

  // ---------------- configuration registers ----------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      on_q <= 1'b0;
      auto_conv_q <= 1'b0;
      auto_sample_restart_q <= 1'b0;
      dma_en_q <= 1'b0;
      scan_en_q <= 1'b0;
      alt_q <= 1'b0;
      smpi_q <= SMPI_RST;
      chs0_q <= CHS0_RST;
      scan_sel_q <= SCAN_RST;
      sample_control_bit_time_q <= SAMPLE_CONTROL_BIT_TIME_RST;
      amp_mode_q <= 3'h0;
      irq_mask_q <= IRQ_MASK_RST;
    end else if (acc_wr) begin
      unique case ({wb_adr_i[7:2], 2'b00})
        OFS_CTRL1: begin
          if (wb_sel_i[1]) on_q <= wb_dat_i[CTRL1_ON_BIT];
          if (wb_sel_i[0]) auto_conv_q <= wb_dat_i[CTRL1_AUTO_CONV_BIT];
          if (wb_sel_i[0]) auto_sample_restart_q <= wb_dat_i[CTRL1_AUTO_SAMPLE_RESTART_BIT];
        end
        OFS_CTRL2: begin
          if (wb_sel_i[1]) dma_en_q <= wb_dat_i[CTRL2_DMA_BIT];
          if (wb_sel_i[1]) scan_en_q <= wb_dat_i[CTRL2_SCAN_BIT];
          if (wb_sel_i[0]) smpi_q <= wb_dat_i[CTRL2_SMPI_LSB +: 5];
          if (wb_sel_i[0]) alt_q <= wb_dat_i[CTRL2_ALT_BIT];
        end
        OFS_CHS0: chs0_q <= merge16(chs0_q, wb_dat_i[15:0], wmask) & CHS0_MASK;
        OFS_SCAN_LO: scan_sel_q[15:0] <= merge16(scan_sel_q[15:0], wb_dat_i[15:0], wmask);
        OFS_SCAN_HI: scan_sel_q[31:16] <= merge16(scan_sel_q[31:16], wb_dat_i[15:0], wmask);
        OFS_SAMPLE_CONTROL_BIT_TIME: if (wb_sel_i[0]) sample_control_bit_time_q <= wb_dat_i[4:0];
        OFS_AMP_MODE: if (wb_sel_i[0]) amp_mode_q <= wb_dat_i[2:0];
        OFS_IRQ_MASK: if (wb_sel_i[0]) irq_mask_q <= wb_dat_i[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // results are unreliable while the analog stage settles after switch-on
  always_ff @(posedge clk_i) begin
    if (rst_i || !on_q) begin
      settle_cnt_q <= 9'h000;
      ready_q <= 1'b0;
    end else if (settle_cnt_q == SETTLE_LAST) begin
      ready_q <= 1'b1;
    end else begin
      settle_cnt_q <= settle_cnt_q + 9'h001;
    end
  end

  // ---------------- phase sequencer ----------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      S_IDLE: if (sample_control_bit_q || auto_sample_restart_q) state_d = S_SAMPLE_CONTROL_BIT_WAIT;
      S_SAMPLE_CONTROL_BIT_WAIT: if (tad_cnt_q == START_TADS) state_d = S_SAMPLE;
      S_SAMPLE: begin
        if (auto_conv_q && tad_cnt_q >= sample_control_bit_time_q) begin
          state_d = S_CONVERT;
        end else if (!auto_conv_q && !sample_control_bit_q) begin
          state_d = S_CONV_WAIT;
        end
      end
      S_CONV_WAIT: if (tad_cnt_q == START_TADS) state_d = S_CONVERT;
      S_CONVERT: if (tad_cnt_q == CONV_TADS) state_d = auto_sample_restart_q ? S_RESTART : S_IDLE;
      S_RESTART: if (half_cnt_q == RESTART_LAST) state_d = S_SAMPLE;
    endcase
    if (!on_q) begin
      state_d = S_IDLE;
    end
  end

  assign phase_change = state_d != state_q;
  assign conv_start = state_d == S_CONVERT && state_q != S_CONVERT;
  assign conv_done = on_q && state_q == S_CONVERT && tad_cnt_q == CONV_TADS;
  assign last = conv_cnt_q == smpi_q;

  tad_timer #(.DIV(TAD_CYCLES)) u_tad (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .restart_i(phase_change),
    .tick_o(tick)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= S_IDLE;
      tad_cnt_q <= 5'h00;
      half_cnt_q <= 4'h0;
    end else begin
      state_q <= state_d;
      if (phase_change) begin
        tad_cnt_q <= 5'h00;
      end else if (tick && tad_cnt_q != 5'h1F) begin
        tad_cnt_q <= tad_cnt_q + 5'h01;
      end
      half_cnt_q <= (state_q == S_RESTART && !phase_change) ? half_cnt_q + 4'h1 : 4'h0;
    end
  end

  // hardware edits to sample and done win over a software write in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sample_control_bit_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      if (state_d == S_SAMPLE && state_q != S_SAMPLE && auto_sample_restart_q) begin
        sample_control_bit_q <= 1'b1;
      end else if (state_q == S_SAMPLE && conv_start) begin
        sample_control_bit_q <= 1'b0;
      end else if (acc_wr && wb_adr_i == OFS_CTRL1 && wb_sel_i[0]) begin
        sample_control_bit_q <= wb_dat_i[CTRL1_SAMPLE_CONTROL_BIT_BIT];
      end
      if (conv_done) begin
        done_q <= 1'b1;
      end else if (conv_start) begin
        done_q <= 1'b0;
      end else if (acc_wr && wb_adr_i == OFS_CTRL1 && wb_sel_i[0]) begin
        done_q <= wb_dat_i[CTRL1_DONE_BIT];
      end
    end
  end

  // ---------------- result buffering, scan and dma pacing ----------------
  assign first_idx = next_set(scan_sel_q, 5'h1F);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_cnt_q <= 5'h00;
      ptr_q <= '0;
      dma_cnt_q <= 5'h00;
      scan_idx_q <= 5'h00;
      use_b_q <= 1'b0;
      dma_addr_inc_o <= 1'b0;
      for (int i = 0; i < NBUF; i++) begin
        buf_q[i] <= '0;
      end
    end else begin
      dma_addr_inc_o <= conv_done && dma_en_q && dma_cnt_q == DMA_LAST;
      if (!scan_en_q) begin
        scan_idx_q <= first_idx;
      end
      if (conv_done) begin
        conv_cnt_q <= last ? 5'h00 : conv_cnt_q + 5'h01;
        use_b_q <= alt_q && !use_b_q;
        if (scan_en_q) begin
          scan_idx_q <= last ? first_idx : next_set(scan_sel_q, scan_idx_q);
        end
        if (dma_en_q) begin
          buf_q[0] <= conv_result_i;
          ptr_q <= '0;
          dma_cnt_q <= dma_cnt_q + 5'h01;
        end else begin
          buf_q[ptr_q] <= conv_result_i;
          ptr_q <= last ? '0 : ptr_q + 1'b1;
        end
      end
    end
  end

  // buffer 0 unread flag lets software see a dma overrun
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      unread_q <= 1'b0;
    end else if (conv_done && dma_en_q) begin
      unread_q <= 1'b1;
    end else if (acc_rd && wb_adr_i == OFS_BUF) begin
      unread_q <= 1'b0;
    end
  end

  // ---------------- interrupts ----------------
  always_comb begin
    irq_set = 3'h0;
    irq_set[IRQ_COUNT_BIT] = conv_done && last;
    irq_set[IRQ_DONE_BIT] = conv_done;
    irq_set[IRQ_OVERRUN_BIT] = conv_done && dma_en_q && unread_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_q <= 3'h0;
      irq_o <= 1'b0;
    end else begin
      if (acc_wr && wb_adr_i == OFS_IRQ_STAT && wb_sel_i[0]) begin
        irq_stat_q <= (irq_stat_q & ~wb_dat_i[IRQ_W-1:0]) | irq_set;
      end else begin
        irq_stat_q <= irq_stat_q | irq_set;
      end
      irq_o <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ---------------- analog routing ----------------
  assign pos_sel = use_b_q ? chs0_q[CHS0_SB_LSB +: 5] :
                   (scan_en_q ? scan_idx_q : chs0_q[CHS0_SA_LSB +: 5]);
  assign neg_sel = use_b_q ? chs0_q[CHS0_NB_BIT] : chs0_q[CHS0_NA_BIT];

  input_router u_router (
    .pos_sel_i(pos_sel),
    .neg_sel_i(neg_sel),
    .amp_mode_i(amp_mode_q),
    .pos_route_o(pos_route),
    .neg_route_o(neg_route)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos_route_o <= 6'h00;
      neg_route_o <= ROUTE_LOW_VOLTAGE_REFERENCE;
      sample_o <= 1'b0;
      converting_o <= 1'b0;
    end else begin
      pos_route_o <= pos_route;
      neg_route_o <= neg_route;
      sample_o <= state_d == S_SAMPLE;
      converting_o <= state_d == S_CONVERT;
    end
  end

  // ---------------- checks ----------------
  count_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
    conv_done && last |=> irq_stat_q[IRQ_COUNT_BIT] && conv_cnt_q == 5'h00)
    else $error("count interrupt not flagged at end of count");
  scan_restart_a: assert property (@(posedge clk_i) disable iff (rst_i)
    conv_done && last && scan_en_q |=> scan_idx_q == $past(first_idx))
    else $error("scan list did not restart");
  ptr_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
    conv_done && !dma_en_q |=> ptr_q == ($past(last) ? '0 : $past(ptr_q) + 1'b1))
    else $error("buffer pointer stepped wrongly");
  dma_pace_a: assert property (@(posedge clk_i) disable iff (rst_i)
    dma_addr_inc_o |-> $past(conv_done) && $past(dma_cnt_q) == DMA_LAST && ptr_q == '0)
    else $error("dma advance at wrong conversion");
  done_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    conv_done |=> done_q [*2])
    else $error("done flag not held after conversion");
  done_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    conv_start |=> !done_q && converting_o)
    else $error("done flag not cleared at conversion start");
  neg_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 neg_route_o == ($past(neg_sel) ? ROUTE_AN1 : ROUTE_LOW_VOLTAGE_REFERENCE))
    else $error("negative input routed wrongly");
  amp_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
    pos_sel == SEL_AMP1 |=> pos_route_o == ($past(amp_mode_q[0]) ? ROUTE_AMP1 : AMP_PIN[0]))
    else $error("amplifier output routed without its mode bit");
  conv_delay_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == S_CONV_WAIT && state_d == S_CONVERT |-> tad_cnt_q == START_TADS)
    else $error("conversion start delay wrong");
  sample_control_bit_delay_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(sample_o) && $past(state_q) == S_SAMPLE_CONTROL_BIT_WAIT |-> $past(tad_cnt_q) == START_TADS)
    else $error("sample start delay wrong");
  conv_length_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(converting_o) && on_q |-> $past(tad_cnt_q) == CONV_TADS)
    else $error("conversion length wrong");
endmodule
`default_nettype wire

// *** testbench/result_source.sv ***
// converter result source and dma pulse counter at the far side of the sequencer
`timescale 1ns/1ps
`default_nettype none
module result_source (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic converting_i,
  input wire logic dma_inc_i,
  output logic [11:0] result_o,
  output logic [7:0] conv_cnt_o,
  output logic [7:0] dma_cnt_o
);
  logic busy_q;
  // never reads buffer 0, so in dma mode each result is overwritten on purpose
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
      result_o <= 12'h100;
      conv_cnt_o <= 8'h00;
      dma_cnt_o <= 8'h00;
    end else begin
      busy_q <= converting_i;
      // a fresh value per conversion keeps every buffer slot traceable
      if (converting_i && !busy_q) result_o <= result_o + 12'h001;
      if (!converting_i && busy_q) conv_cnt_o <= conv_cnt_o + 8'h01;
      if (dma_inc_i) dma_cnt_o <= dma_cnt_o + 8'h01;
    end
  end
endmodule
`default_nettype wire

// *** testbench/adc_sequencer_bench.sv ***
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module adc_sequencer_bench;
  import adc_seq_pkg::*;
  localparam logic [31:0] ON = 32'(1 << CTRL1_ON_BIT) | 32'(1 << CTRL1_AUTO_CONV_BIT);
  localparam logic [31:0] RUN = ON | 32'(1 << CTRL1_AUTO_SAMPLE_RESTART_BIT) | 32'(1 << CTRL1_SAMPLE_CONTROL_BIT_BIT);
  localparam logic [31:0] SMPI4 = 32'(3) << CTRL2_SMPI_LSB;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack, sample, conv, dma_inc, irq;
  logic [5:0] pos, neg;
  logic [11:0] result;
  logic [7:0] conv_cnt, dma_cnt;
  int error_cnt = 0;
  int checks = 0;
  logic [15:0] cs_t [9] = '{16'h0000, 16'h008F, 16'h0018, 16'h0018, 16'h0019, 16'h001A,
    16'h001E, 16'h001F, 16'h0010};
  logic [2:0] am_t [9] = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h2, 3'h0, 3'h0, 3'h0, 3'h0};
  logic [5:0] pr_t [9] = '{6'h00, 6'h0F, 6'h03, 6'h10, 6'h11, 6'h06, 6'h13, 6'h14, 6'h15};
  logic [11:0] buf_t [4] = '{12'h105, 12'h106, 12'h103, 12'h104};

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  adc_sequencer dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .conv_result_i(result), .sample_o(sample), .converting_o(conv),
    .pos_route_o(pos), .neg_route_o(neg), .dma_addr_inc_o(dma_inc), .irq_o(irq));
  result_source src (.clk_i(clk_i), .rst_i(rst_i), .converting_i(conv), .dma_inc_i(dma_inc),
    .result_o(result), .conv_cnt_o(conv_cnt), .dma_cnt_o(dma_cnt));

  task automatic test_done;
    if (error_cnt == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // classic single cycle; the request holds until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    check(32'(n < 20), 32'h1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0000_0000);
    check(q, exp);
  endtask

  task automatic wait_conv(input logic [7:0] n, input logic busy);
    int t;
    t = 0;
    do begin
      @(posedge clk_i);
      t++;
    end while (!(conv_cnt == n && conv === busy) && t < 5000);
  endtask

  // free-running conversions; auto restart is dropped during the last one
  task automatic run(input logic [31:0] ctrl2, input logic [7:0] n);
    logic [7:0] last;
    last = conv_cnt + n;
    wb(1'b1, OFS_CTRL2, ctrl2);
    wb(1'b1, OFS_CTRL1, RUN);
    wait_conv(last - 8'h01, 1'b1);
    wb(1'b1, OFS_CTRL1, ON);
    wb(1'b0, OFS_CTRL1, 32'h0000_0000);
    check(32'(q[CTRL1_DONE_BIT]), 32'h0);
    wait_conv(last, 1'b0);
    repeat (20) @(posedge clk_i);
    check(32'(conv_cnt), 32'(last));
    wb(1'b0, OFS_CTRL1, 32'h0000_0000);
    check(32'(q[CTRL1_DONE_BIT]), 32'h1);
  endtask

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFS_CHS0, 32'(CHS0_RST));
    rd(OFS_SAMPLE_CONTROL_BIT_TIME, 32'(SAMPLE_CONTROL_BIT_TIME_RST));
    rd(8'hF0, 32'h0000_0000);
    wb(1'b1, OFS_CHS0, 32'h0000_FFFF);
    rd(OFS_CHS0, 32'(CHS0_MASK));
    for (int i = 0; i < 9; i++) begin
      wb(1'b1, OFS_AMP_MODE, 32'(am_t[i]));
      wb(1'b1, OFS_CHS0, 32'(cs_t[i]));
      repeat (3) @(posedge clk_i);
      check(32'(pos), 32'(pr_t[i]));
      check(32'(neg), cs_t[i][7] ? 32'(ROUTE_AN1) : 32'(ROUTE_LOW_VOLTAGE_REFERENCE));
    end
    wb(1'b1, OFS_IRQ_MASK, 32'(1 << IRQ_COUNT_BIT));
    run(SMPI4, 8'h06);
    for (int i = 0; i < 4; i++) begin
      rd(OFS_BUF + 8'(4 * i), 32'(buf_t[i]));
    end
    check(32'(irq), 32'h1);
    rd(OFS_IRQ_STAT, 32'h0000_0003);
    wb(1'b1, OFS_IRQ_MASK, 32'h0000_0000);
    repeat (3) @(posedge clk_i);
    check(32'(irq), 32'h0);
    wb(1'b1, OFS_IRQ_STAT, 32'h0000_0007);
    rd(OFS_IRQ_STAT, 32'h0000_0000);
    run(SMPI4 | 32'(1 << CTRL2_DMA_BIT), 8'h21);
    check(32'(dma_cnt), 32'h1);
    rd(OFS_BUF, 32'h0000_0127);
    rd(OFS_BUF + 8'h04, 32'h0000_0106);
    rd(OFS_IRQ_STAT, 32'h0000_0007);
    // manual sampling with scanning: first pass ends a count, so the list restarts at input 1
    wb(1'b1, OFS_SCAN_LO, 32'h0000_0006);
    wb(1'b1, OFS_CTRL2, SMPI4 | 32'(1 << CTRL2_SCAN_BIT));
    for (int i = 1; i < 3; i++) begin
      wb(1'b1, OFS_CTRL1, 32'(1 << CTRL1_ON_BIT) | 32'(1 << CTRL1_SAMPLE_CONTROL_BIT_BIT));
      repeat (3) @(posedge clk_i);
      check(32'(sample), 32'h0);
      repeat (9) @(posedge clk_i);
      check(32'(sample), 32'h1);
      wb(1'b1, OFS_CTRL1, 32'(1 << CTRL1_ON_BIT));
      wait_conv(conv_cnt + 8'h01, 1'b0);
      repeat (2) @(posedge clk_i);
      check(32'(pos), 32'(i));
    end
    test_done;
  end

  initial begin
    #(50 * 30000);
    error_cnt++;
    test_done;
  end
endmodule
`default_nettype wire
